// *** spfsw_chk.sv ***
// concurrent checks on the ports of the flash command logic
module spfsw_chk import spfsw_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int TW_CYCLES = TW_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic cs_b,
  input wire logic wp_b,
  input wire logic so,
  input wire logic so_oe,
  input wire logic [AW-1:0] mem_addr,
  input wire logic busy_flag,
  input wire logic write_unlock_latch,
  input wire logic status_lock_bit,
  input wire logic region_guard_hi,
  input wire logic region_guard_lo,
  input wire logic hardware_locked_state,
  input wire logic software_guarded_state,
  input wire logic guard_hit,
  input wire logic page_write_ok,
  input wire logic full_clear_ok
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  // cycles spent busy, cleared when idle
  int unsigned busy_cnt;
  always_ff @(posedge clk) begin
    if (!rst_b || !busy_flag) begin
      busy_cnt <= 0;
    end else begin
      busy_cnt <= busy_cnt + 1;
    end
  end
  sequence s_write_start; $rose(busy_flag); endsequence
  sequence s_write_end; $fell(busy_flag); endsequence
  property p_busy_len; s_write_end |-> busy_cnt == TW_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length off");
  property p_latch_clr; s_write_start |-> !write_unlock_latch; endproperty
  a_latch_clr: assert property (p_latch_clr) else $error("latch still set");
  property p_bits_hold;
    ($changed(status_lock_bit) || $changed(region_guard_hi) || $changed(region_guard_lo))
      |-> s_write_end;
  endproperty
  a_bits_hold: assert property (p_bits_hold) else $error("status bits moved");
  property p_hw_on; (status_lock_bit && !wp_b)[*6] |-> hardware_locked_state; endproperty
  a_hw_on: assert property (p_hw_on) else $error("locked state missing");
  property p_hw_off; wp_b[*6] |-> !hardware_locked_state; endproperty
  a_hw_off: assert property (p_hw_off) else $error("locked state stuck");
  property p_sw; software_guarded_state == !hardware_locked_state; endproperty
  a_sw: assert property (p_sw) else $error("guard states clash");
  property p_no_write; hardware_locked_state[*4] |-> !$rose(busy_flag); endproperty
  a_no_write: assert property (p_no_write) else $error("write while locked");
  property p_oe_off; cs_b |-> !so_oe && !so; endproperty
  a_oe_off: assert property (p_oe_off) else $error("output driven");
  property p_full_clear;
    full_clear_ok |-> !$past(region_guard_hi) && !$past(region_guard_lo)
      && $past(write_unlock_latch) && !$past(busy_flag);
  endproperty
  a_full_clear: assert property (p_full_clear) else $error("full clear allowed");
  property p_page_write;
    page_write_ok |-> $past(write_unlock_latch) && !$past(busy_flag) && !guard_hit;
  endproperty
  a_page_write: assert property (p_page_write) else $error("page write allowed");
  property p_guard_none; !region_guard_hi && !region_guard_lo |=> !guard_hit; endproperty
  a_guard_none: assert property (p_guard_none) else $error("hit with no guard");
  // status reads stay legal while busy, so watch the read address instead of the output enable
  property p_read_busy; busy_flag[*5] |-> $stable(mem_addr); endproperty
  a_read_busy: assert property (p_read_busy) else $error("read while busy");
endmodule // spfsw_chk

bind spfsw_top spfsw_chk #(.AW(AW), .TW_CYCLES(TW_CYCLES)) i_chk (.clk, .rst_b, .cs_b,
  .wp_b, .so, .so_oe, .busy_flag, .write_unlock_latch, .status_lock_bit, .region_guard_hi,
  .region_guard_lo, .hardware_locked_state, .software_guarded_state, .guard_hit,
  .page_write_ok, .full_clear_ok, .mem_addr);

// *** spfsw_host.sv ***
// serial bus master model: mode 0, link clock runs only inside frames
module spfsw_host (
  output logic sck,
  output logic cs_b,
  output logic si,
  input wire logic so,
  input wire logic so_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck = 1'b0;
    cs_b = 1'b1;
    si = 1'b0;
  end
  // nin bits of d msb first, then nout bits taken from so
  task automatic frame(input logic [31:0] d, input int nin, input int nout,
      output logic [31:0] q, output logic oe);
    q = '0;
    oe = 1'b0;
    cs_b = 1'b0;
    for (int i = 0; i < nin + nout; i++) begin
      // past the command the data line toggles, so a stale bit is never seen
      si = (i < nin) ? d[31-i] : ~si;
      #3 sck = 1'b1;
      if (i >= nin) begin
        q = {q[30:0], so};
        oe = oe | so_oe;
      end
      #3 sck = 1'b0;
    end
    #3 cs_b = 1'b1;
    si = ~si;
    // gap so the core sees the frame summary
    #60;
  endtask
endmodule // spfsw_host

// *** spfsw_link.sv ***
// serial link logic: shifts commands in, read data out, on the link clock
module spfsw_link import spfsw_pkg::*; #(
  parameter int AW = ADDR_W
) (
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic [7:0] mem_rdata,
  output logic so,
  output logic so_oe,
  output logic [AW-1:0] mem_addr,
  spfsw_link_if.link lk
);

  logic [2:0] bit_ph;
  logic [2:0] byte_n;
  logic [7:0] shreg;
  logic [7:0] op;
  logic [7:0] dat;
  logic [15:0] addr_hi;
  logic rd_go;
  logic st_go;
  logic [7:0] st_meta;
  logic [7:0] st_sync;
  logic [7:0] out_sr;
  logic [7:0] next_byte;
  logic load;
  logic [7:0] src;
  // always the full three-byte address; the array may decode fewer bits
  logic [23:0] addr_full;

  assign next_byte = {shreg[6:0], si};
  assign addr_full = {addr_hi, next_byte};
  assign load = (bit_ph == 3'h0) &&
    ((rd_go && byte_n == BYTE_SAT) || (st_go && byte_n != 3'h0));
  assign src = rd_go ? mem_rdata : (st_sync & ST_READ_MASK);

  // ----------------------------------------------------------------
  // status crossing; quasi-static, settles during the opcode byte
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      st_meta <= 8'h00;
      st_sync <= 8'h00;
    end else begin
      st_meta <= lk.status;
      st_sync <= st_meta;
    end
  end

  // ----------------------------------------------------------------
  // input shifting on rising edges; select high clears the frame
  // ----------------------------------------------------------------
  always_ff @(posedge sck or posedge cs_b) begin
    if (cs_b) begin
      bit_ph <= 3'h0;
      byte_n <= 3'h0;
      shreg <= 8'h00;
      op <= 8'h00;
      dat <= 8'h00;
      addr_hi <= 16'h0000;
      rd_go <= 1'b0;
      st_go <= 1'b0;
      mem_addr <= '0;
    end else begin
      bit_ph <= bit_ph + 3'h1;
      shreg <= next_byte;
      if (bit_ph == 3'h7) begin
        if (byte_n != BYTE_SAT) begin
          byte_n <= byte_n + 3'h1;
        end
        if (byte_n == 3'h0) begin
          op <= next_byte;
          rd_go <= (next_byte == OP_READ) && !st_sync[ST_BUSY];
          st_go <= (next_byte == OP_STATUS_RD);
        end
        if (byte_n == 3'h1) begin
          dat <= next_byte;
        end
        if (byte_n != BYTE_SAT) begin
          addr_hi <= {addr_hi[7:0], next_byte};
        end
        if (rd_go && byte_n == ADDR_LAST_BYTE) begin
          mem_addr <= addr_full[AW-1:0];
        end else if (rd_go && byte_n == BYTE_SAT) begin
          mem_addr <= mem_addr + AW'(1);
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // output shifting on falling edges; released while deselected
  // ----------------------------------------------------------------
  always_ff @(negedge sck or posedge cs_b) begin
    if (cs_b) begin
      so <= 1'b0;
      so_oe <= 1'b0;
      out_sr <= 8'h00;
    end else if (load) begin
      so <= src[7];
      so_oe <= 1'b1;
      out_sr <= {src[6:0], 1'b0};
    end else if (so_oe) begin
      so <= out_sr[7];
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // ----------------------------------------------------------------
  // frame summary, frozen by the select rise for the core to read
  // ----------------------------------------------------------------
  always_ff @(posedge cs_b) begin
    lk.done_op <= op;
    lk.done_dat <= dat;
    lk.done_bytes <= byte_n;
    lk.done_aligned <= (bit_ph == 3'h0);
  end

endmodule // spfsw_link

// *** spfsw_link_if.sv ***
// carrier between the core (clk) and the serial link logic (sck)
interface spfsw_link_if;
  logic [7:0] status;
  logic [7:0] done_op;
  logic [7:0] done_dat;
  logic [2:0] done_bytes;
  logic done_aligned;

  modport core (output status, input done_op, input done_dat, input done_bytes,
    input done_aligned);
  modport link (input status, output done_op, output done_dat, output done_bytes,
    output done_aligned);
endinterface : spfsw_link_if

// *** spfsw_pkg.sv ***
// constants shared by the status write / protection / read command logic
package spfsw_pkg;

  // ----------------------------------------------------------------
  // command opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_STATUS_WR = 8'h01;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_RELOCK = 8'h04;
  localparam logic [7:0] OP_STATUS_RD = 8'h05;
  localparam logic [7:0] OP_UNLOCK = 8'h06;

  // ----------------------------------------------------------------
  // status byte layout
  // ----------------------------------------------------------------
  localparam int ST_BUSY = 0;
  localparam int ST_UNLOCK = 1;
  localparam int ST_GUARD_LO = 2;
  localparam int ST_GUARD_HI = 3;
  localparam int ST_LOCK = 7;
  localparam logic [7:0] ST_READ_MASK = 8'h8f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic LOCK_RST = 1'b0;
  localparam logic [1:0] GUARD_RST = 2'h0;
  localparam logic UNLOCK_RST = 1'b0;

  // ----------------------------------------------------------------
  // frame framing and timing
  // ----------------------------------------------------------------
  localparam int ADDR_W = 24;
  localparam logic [2:0] BYTE_SAT = 3'h4;
  localparam logic [2:0] STATUS_WR_BYTES = 3'h2;
  localparam logic [2:0] ADDR_LAST_BYTE = 3'h3;
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_W_NS = 15000000;
  localparam int TW_CYC = (T_W_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage : spfsw_pkg

// *** spfsw_tb_top.sv ***
// self-checking bench for the status write, protection and read logic
module spfsw_tb_top import spfsw_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TW = 20;
  logic clk, rst_b, wp_b, sck, cs_b, si, so, so_oe, oe;
  logic busy_flag, write_unlock_latch, status_lock_bit, region_guard_hi, region_guard_lo;
  logic hardware_locked_state, software_guarded_state, guard_hit, page_write_ok;
  logic full_clear_ok;
  logic [7:0] mem_rdata, guard_addr, mem_addr;
  logic [31:0] q;
  int failures = 0;
  int checks = 0;
  // storage pattern: every byte differs from its neighbours
  assign mem_rdata = mem_addr ^ 8'h5a;
  spfsw_top #(.AW(8), .TW_CYCLES(TW)) i_dut (.clk, .rst_b, .sck, .cs_b, .si, .wp_b,
    .mem_rdata, .guard_addr, .so, .so_oe, .mem_addr, .busy_flag, .write_unlock_latch,
    .status_lock_bit, .region_guard_hi, .region_guard_lo, .hardware_locked_state,
    .software_guarded_state, .guard_hit, .page_write_ok, .full_clear_ok);
  spfsw_host i_host (.sck, .cs_b, .si, .so, .so_oe);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic end_sim;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask
  // frames end off the core clock; realign so core inputs change on falling edges
  task automatic xfer(input logic [31:0] d, input int nin, input int nout);
    i_host.frame(d, nin, nout, q, oe);
    @(negedge clk);
  endtask
  task automatic cmd(input logic [31:0] d, input int nin);
    xfer(d, nin, 0);
  endtask
  task automatic wsr(input logic [7:0] b);
    cmd({OP_UNLOCK, 24'h0}, 8);
    cmd({OP_STATUS_WR, b, 16'h0}, 16);
  endtask
  task automatic rdsr(input logic [7:0] e);
    xfer({OP_STATUS_RD, 24'h0}, 8, 8);
    chk("status", q[7:0], e);
  endtask
  task automatic wait_idle;
    repeat (TW + 20) begin
      if (busy_flag === 1'b0) break;
      @(negedge clk);
    end
    chk("busy", busy_flag, 1'b0);
  endtask
  task automatic t_reset;
    chk("lock", status_lock_bit, 1'b0);
    chk("latch", write_unlock_latch, 1'b0);
    chk("guards", {region_guard_hi, region_guard_lo}, 2'h0);
    chk("sw", software_guarded_state, 1'b1);
    cmd({OP_STATUS_WR, 8'h0c, 16'h0}, 16);
    settle(10);
    chk("busy", busy_flag, 1'b0);
    $display("reset and refusal test done");
  endtask
  task automatic t_fields;
    wsr(8'h7c);
    chk("busy", busy_flag, 1'b1);
    chk("latch", write_unlock_latch, 1'b0);
    rdsr(8'h01);
    wait_idle;
    rdsr(8'h0c);
    guard_addr = 8'h00;
    settle(3);
    chk("hit", guard_hit, 1'b1);
    chk("full", full_clear_ok, 1'b0);
    chk("page", page_write_ok, 1'b0);
    $display("status write test done");
  endtask
  task automatic t_read;
    xfer({OP_READ, 24'h0000fe}, 32, 27);
    chk("read", q[26:0], {8'ha4, 8'ha5, 8'h5a, 3'h2});
    chk("oe", oe, 1'b1);
    $display("read test done");
  endtask
  task automatic t_count;
    cmd({OP_UNLOCK, 24'h0}, 8);
    cmd({OP_STATUS_WR, 8'h00, 16'h0}, 15);
    chk("busy", busy_flag, 1'b0);
    chk("latch", write_unlock_latch, 1'b1);
    wsr(8'h00);
    xfer({OP_READ, 24'h0}, 32, 8);
    chk("oe", oe, 1'b0);
    wait_idle;
    chk("guards", {region_guard_hi, region_guard_lo}, 2'h0);
    cmd({OP_UNLOCK, 24'h0}, 8);
    guard_addr = 8'hff;
    settle(3);
    chk("page", page_write_ok, 1'b1);
    chk("full", full_clear_ok, 1'b1);
    cmd({OP_RELOCK, 24'h0}, 8);
    chk("latch", write_unlock_latch, 1'b0);
    $display("count and busy test done");
  endtask
  task automatic t_locks;
    wsr(8'h84);
    wait_idle;
    chk("lock", {status_lock_bit, region_guard_lo}, 2'h3);
    settle(3);
    chk("hit", guard_hit, 1'b1);
    guard_addr = 8'h00;
    settle(3);
    chk("hit", guard_hit, 1'b0);
    wp_b = 1'b0;
    settle(6);
    chk("hw", {hardware_locked_state, software_guarded_state}, 2'h2);
    wsr(8'h00);
    chk("busy", busy_flag, 1'b0);
    chk("lock", status_lock_bit, 1'b1);
    wp_b = 1'b1;
    settle(6);
    chk("hw", hardware_locked_state, 1'b0);
    wsr(8'h00);
    wait_idle;
    chk("lock", status_lock_bit, 1'b0);
    wp_b = 1'b0;
    wsr(8'h08);
    wait_idle;
    chk("guard hi", region_guard_hi, 1'b1);
    wp_b = 1'b1;
    $display("protection test done");
  endtask
  initial begin
    rst_b = 1'b0;
    wp_b = 1'b1;
    guard_addr = 8'h00;
    settle(12);
    rst_b = 1'b1;
    settle(4);
    t_reset;
    t_fields;
    t_read;
    t_count;
    t_locks;
    end_sim;
  end
  // whole run is a few microseconds
  initial begin
    #200000;
    failures++;
    end_sim;
  end
endmodule // spfsw_tb_top

// *** spfsw_top.sv ***
// status write, protection and read command logic of the serial flash
//
// Behaviour
// - status write needs unlock latch set first
// - status write keeps b6,b5,b4,b1,b0 unchanged
// - status bits b6..b4 always read zero
// - select must rise right after data byte
// - select rise starts timed status update cycle
// - status readable, busy high during cycle only
// - unlock latch cleared before cycle ends
// - status write sets region guards and lock
// - no status write in hardware locked state
// - lock bit zero: writes allowed, pin ignored
// - lock bit starts at zero
// - lock set, pin high: writes allowed
// - lock set, pin low: writes rejected
// - locked state whenever lock set, pin low
// - only pin high leaves the locked state
// - read opcode, 3-byte address, rising-edge sampled
// - read data shifted out on falling edges
// - read address increments and wraps to zero
// - select rise ends read at any bit
// - reads rejected while a cycle is busy
// - opcodes 01h status write, 03h read, 06h unlock
// - status write needs whole byte count
// - full clear only with both guards zero
// - unlock latch cleared at reset and relock
module spfsw_top import spfsw_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int TW_CYCLES = TW_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic sck,
  input wire logic cs_b,
  input wire logic si,
  input wire logic wp_b,
  input wire logic [7:0] mem_rdata,
  input wire logic [AW-1:0] guard_addr,
  output logic so,
  output logic so_oe,
  output logic [AW-1:0] mem_addr,
  output logic busy_flag,
  output logic write_unlock_latch,
  output logic status_lock_bit,
  output logic region_guard_hi,
  output logic region_guard_lo,
  output logic hardware_locked_state,
  output logic software_guarded_state,
  output logic guard_hit,
  output logic page_write_ok,
  output logic full_clear_ok
);

  localparam int TMR_W = $clog2(TW_CYCLES + 1);

  typedef enum logic [0:0] {
    WC_IDLE,
    WC_CYCLE
  } spfsw_wcyc_e;

  spfsw_link_if lk ();

  spfsw_wcyc_e state;
  logic [TMR_W-1:0] timer;
  logic cs_meta;
  logic cs_sync;
  logic cs_prev;
  logic wp_meta;
  logic wp_sync;
  logic frame_end;
  logic whole_bytes;
  logic unlock_hit;
  logic relock_hit;
  logic status_wr_hit;
  logic status_wr_ok;
  logic pend_lock;
  logic [1:0] pend_guard;
  logic [1:0] guard;
  logic locked_now;
  logic [7:0] status_byte;

  // ----------------------------------------------------------------
  // serial link
  // ----------------------------------------------------------------
  spfsw_link #(
    .AW(AW)
  ) u_link (
    .sck(sck),
    .cs_b(cs_b),
    .si(si),
    .mem_rdata(mem_rdata),
    .so(so),
    .so_oe(so_oe),
    .mem_addr(mem_addr),
    .lk(lk.link)
  );

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cs_meta <= 1'b1;
      cs_sync <= 1'b1;
      cs_prev <= 1'b1;
    end else begin
      cs_meta <= cs_b;
      cs_sync <= cs_meta;
      cs_prev <= cs_sync;
    end
  end

  // pulled high at reset so a floating protect pin starts unlocked
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wp_meta <= 1'b1;
      wp_sync <= 1'b1;
    end else begin
      wp_meta <= wp_b;
      wp_sync <= wp_meta;
    end
  end

  // ----------------------------------------------------------------
  // frame decode at select rise
  // ----------------------------------------------------------------
  // the summary registers were frozen by the same rise and stay put
  // until the next frame ends, so reading them two cycles late is safe
  assign frame_end = cs_sync && !cs_prev;
  assign whole_bytes = lk.done_aligned && (lk.done_bytes != 3'h0);
  assign unlock_hit = frame_end && whole_bytes && (lk.done_bytes == 3'h1) &&
    (lk.done_op == OP_UNLOCK);
  assign relock_hit = frame_end && whole_bytes && (lk.done_bytes == 3'h1) &&
    (lk.done_op == OP_RELOCK);
  assign status_wr_hit = frame_end && whole_bytes &&
    (lk.done_bytes == STATUS_WR_BYTES) && (lk.done_op == OP_STATUS_WR);
  assign locked_now = status_lock_bit && !wp_sync;
  assign status_wr_ok = status_wr_hit && write_unlock_latch &&
    !locked_now && !hardware_locked_state && (state == WC_IDLE);

  assign guard = {region_guard_hi, region_guard_lo};

  // ----------------------------------------------------------------
  // status update cycle
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= WC_IDLE;
      timer <= '0;
      busy_flag <= 1'b0;
    end else begin
      unique case (state)
        WC_IDLE: begin
          if (status_wr_ok) begin
            state <= WC_CYCLE;
            timer <= TMR_W'(TW_CYCLES - 1);
            busy_flag <= 1'b1;
          end
        end
        WC_CYCLE: begin
          if (timer == '0) begin
            state <= WC_IDLE;
            busy_flag <= 1'b0;
          end else begin
            timer <= timer - TMR_W'(1);
          end
        end
      endcase
    end
  end

  // only the guard and lock fields are taken from the data byte
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pend_lock <= LOCK_RST;
      pend_guard <= GUARD_RST;
    end else if (status_wr_ok) begin
      pend_lock <= lk.done_dat[ST_LOCK];
      pend_guard <= {lk.done_dat[ST_GUARD_HI], lk.done_dat[ST_GUARD_LO]};
    end
  end

  // new protection takes effect when the cycle completes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_lock_bit <= LOCK_RST;
      region_guard_hi <= GUARD_RST[1];
      region_guard_lo <= GUARD_RST[0];
    end else if (state == WC_CYCLE && timer == '0) begin
      status_lock_bit <= pend_lock;
      region_guard_hi <= pend_guard[1];
      region_guard_lo <= pend_guard[0];
    end
  end

  // ----------------------------------------------------------------
  // write unlock latch
  // ----------------------------------------------------------------
  // cleared as the cycle starts, well before it finishes
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      write_unlock_latch <= UNLOCK_RST;
    end else if (status_wr_ok || relock_hit) begin
      write_unlock_latch <= 1'b0;
    end else if (unlock_hit && state == WC_IDLE) begin
      write_unlock_latch <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // protection states
  // ----------------------------------------------------------------
  // entered from either order of lock bit and pin; left only by the pin
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hardware_locked_state <= 1'b0;
      software_guarded_state <= 1'b1;
    end else begin
      if (locked_now) begin
        hardware_locked_state <= 1'b1;
      end else if (wp_sync) begin
        hardware_locked_state <= 1'b0;
      end
      software_guarded_state <= !locked_now && !(hardware_locked_state && !wp_sync);
    end
  end

  // ----------------------------------------------------------------
  // guarded region check for program and clear requests
  // ----------------------------------------------------------------
  function automatic logic in_guard(input logic [AW-1:0] a, input logic [1:0] g);
    logic hit;
    hit = 1'b0;
    unique case (g)
      2'h0: hit = 1'b0;
      2'h1: hit = (a[AW-1:AW-2] == 2'h3);
      2'h2: hit = a[AW-1];
      2'h3: hit = 1'b1;
    endcase
    return hit;
  endfunction

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      guard_hit <= 1'b0;
      page_write_ok <= 1'b0;
      full_clear_ok <= 1'b0;
    end else begin
      guard_hit <= in_guard(guard_addr, guard);
      page_write_ok <= !in_guard(guard_addr, guard) && write_unlock_latch &&
        !busy_flag;
      full_clear_ok <= (guard == 2'h0) && write_unlock_latch && !busy_flag;
    end
  end

  // ----------------------------------------------------------------
  // status byte toward the link
  // ----------------------------------------------------------------
  // a status read sees this a few link edges late; polling covers it
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      status_byte <= 8'h00;
    end else begin
      status_byte <= 8'h00;
      status_byte[ST_BUSY] <= busy_flag;
      status_byte[ST_UNLOCK] <= write_unlock_latch;
      status_byte[ST_GUARD_LO] <= region_guard_lo;
      status_byte[ST_GUARD_HI] <= region_guard_hi;
      status_byte[ST_LOCK] <= status_lock_bit;
    end
  end

  assign lk.status = status_byte;

endmodule // spfsw_top
